/* verilog/nsdf_pkg.sv */
// nsdf_pkg: offsets, fields, commands and types
// assumes a 50 MHz pclk and an APB master with 32-bit data
package nsdf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_DIAG    = 8'h04;
    localparam logic [7:0] OFS_CMD     = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0C;
    localparam logic [7:0] OFS_CONFIG  = 8'h10;
    localparam logic [7:0] OFS_DUPLICATE_NODE_FLAG   = 8'h14;
    localparam logic [7:0] OFS_PROBE_ID_MATCH_FLAG  = 8'h18;
    localparam logic [7:0] OFS_NEXTID  = 8'h1C;
    // status bit positions
    localparam int ST_TA    = 0;
    localparam int ST_TMA   = 1;
    localparam int ST_LINE_IDLE_TIMEOUT_FLAG = 2;
    localparam int ST_TEST  = 3;
    localparam int ST_POR   = 4;
    localparam int ST_RI    = 7;
    // diagnostic bit positions
    localparam int DG_NXTID = 1;
    localparam int DG_TENT  = 2;
    localparam int DG_XNAK  = 3;
    localparam int DG_TOKEN = 4;
    localparam int DG_RACT  = 5;
    localparam int DG_DUP   = 6;
    localparam int DG_MYREC = 7;
    // config bit positions
    localparam int CF_FOURNAK = 0;
    localparam int CF_TXEN    = 1;
    localparam int CF_SRESET  = 7;
    // clear-flags argument bits
    localparam int CL_POR   = 3;
    localparam int CL_LINE_IDLE_TIMEOUT_FLAG = 4;
    // command codes and match masks
    localparam logic [7:0] CMD_DIS_TX    = 8'h01;
    localparam logic [7:0] CMD_CLR_MASK  = 8'hE7;
    localparam logic [7:0] CMD_CLR_CODE  = 8'h06;
    localparam logic [7:0] CMD_ETX_MASK  = 8'hC7;
    localparam logic [7:0] CMD_ETX_CODE  = 8'h03;
    // reset values
    localparam logic [7:0] RST_STATUS = 8'h91;
    localparam logic [7:0] RST_DIAG   = 8'h00;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    // nak thresholds
    localparam logic [7:0] NAK_FEW  = 8'h04;
    localparam logic [7:0] NAK_MANY = 8'h80;
    // line idle time
    localparam int IDLE_NS    = 41000;
    localparam int CLK_MHZ    = 50;
    localparam int IDLE_CYC   = (IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] IDLE_LAST = 12'(IDLE_CYC - 1);

    typedef enum logic [3:0] {
        NSDF_TX_IDLE = 4'b0001,
        NSDF_TX_PEND = 4'b0010,
        NSDF_TX_SEND = 4'b0100,
        NSDF_TX_STOP = 4'b1000
    } nsdf_tx_t;

    // events from the line protocol engine
    typedef struct packed {
        logic       token_obs;   // a token passed on the line
        logic       token_other; // that token came from another node
        logic [7:0] did1;        // first destination id byte
        logic [7:0] did2;        // second destination id byte
        logic       zeros_ok;    // trailing zero bytes correct
        logic       response;    // a response followed the last token
        logic       token_held;  // this node received the token
        logic       lost_token;  // lost token timer expired
        logic       nak_rx;      // nak answered free buffer enquiry
        logic       ack_rx;      // ack of our packet received
        logic       tx_last;     // last byte of our packet sent
        logic       tx_bcast;    // current packet is a broadcast
        logic       next_upd;    // next id register was updated
        logic [7:0] next_id;     // current next id value
    } nsdf_net_t;

    // requests to the line protocol engine
    typedef struct packed {
        logic       tx_start;    // start sending from tx_page
        logic [2:0] tx_page;     // page and offset bit
        logic       tx_enable;   // transmitter on line
    } nsdf_eng_t;
endpackage : nsdf_pkg

/* verilog/nsdf_top.sv */
// nsdf_top: status and diagnostic flags of a token-passing node, APB slave
// assumes network events arrive as one-cycle pulses synchronous to pclk
//
// Overview of operation
// - status bit 3 always reads zero in normal operation
// - line idle for 41 us sets the line idle timeout flag
// - only clear-flags command or reset clears line idle timeout flag
// - irq on masked idle, tx available, excess nak, successor
// - tx acknowledged set on ack; valid only after tx available set
// - broadcast packets never set tx acknowledged
// - enable-transmit command clears tx acknowledged
// - tx available set after last byte or on the next token held after disable transmitter
// - enable-transmit clears tx available when token is next held
// - lost token timeout sets self caused reconfiguration flag
// - duplicate flag: both id bytes match, zeros ok, response seen
// - duplicate flag also set on every token held while tx enabled
// - logic one on line receive input sets rx activity flag
// - token from another node sets token seen flag
// - excess nak flag after 4 or 128 naks to enquiry
// - excess nak cleared by por clear or tx available; reads keep it
// - probe id match: response after token with first id byte equal
// - diag read clears all but excess nak, successor; reset clears all
// - status register resets to 1xx1 0001
// - diagnostic register resets to 0000 000x
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module nsdf_top
    import nsdf_pkg::*;
(
    input  wire logic        pclk,      // 50 MHz clock
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        clk_en,    // freezes all state while low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error on unmapped address
    input  wire logic        line_receive_input, // line receive input
    input  nsdf_net_t        net,       // events from the line engine
    output nsdf_eng_t        eng,       // requests to the line engine
    output logic             irq        // interrupt, active high
);

    typedef struct packed {
        nsdf_tx_t   tx_state;

        logic       tx_available_flag;
        logic       tx_ack_flag;
        logic       line_idle_timeout_flag;
        logic       por_flag;
        logic       rx_inhibit_flag;
        logic       self_caused_reconfig_flag;
        logic       duplicate_node_flag;
        logic       rx_activity_flag;
        logic       token_seen_flag;
        logic       excess_nak_flag;
        logic       probe_id_match_flag;
        logic       successor_changed_flag;

        logic [11:0] idle_cnt;
        logic       idle_done;
        logic [7:0] nak_cnt;

        logic [7:0] interrupt_mask_reg;
        logic [7:0] cfg;
        logic [7:0] dup_id;
        logic [7:0] tent_id;
        logic       tok_dup;
        logic       tok_tent;

        logic [2:0] page;
        logic       tx_start;
        logic [7:0] rdata;
        logic       rd_diag;
        logic       rd_next;
        logic       err;
    } nsdf_st_t;

    nsdf_st_t st;
    nsdf_st_t next_st;

    logic       setup_ph;
    logic       access_ph;
    logic       wr;
    logic       mapped;
    logic [7:0] wbyte;
    logic [7:0] status_v;
    logic [7:0] diag_v;

    logic       cmd_etx;
    logic       cmd_dis;
    logic       cmd_clr;
    logic       soft_rst;
    logic [7:0] nak_lim;
    logic       clr_dg;

    // apb decode; zero wait states, read data captured at setup
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr        = access_ph & pwrite;
    assign wbyte     = pwdata[7:0];
    assign pready    = 1'b1;
    assign pslverr   = access_ph & st.err;
    assign prdata    = {24'h00_0000, st.rdata};

    always_comb begin
        case (paddr)
            OFS_STATUS, OFS_DIAG, OFS_CMD, OFS_MASK,
            OFS_CONFIG, OFS_DUPLICATE_NODE_FLAG, OFS_PROBE_ID_MATCH_FLAG, OFS_NEXTID: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // visible register images
    always_comb begin
        status_v              = RST_ZERO;
        status_v[ST_RI]       = st.rx_inhibit_flag;
        status_v[ST_POR]      = st.por_flag;
        status_v[ST_TEST]     = 1'b0;
        status_v[ST_LINE_IDLE_TIMEOUT_FLAG]    = st.line_idle_timeout_flag;
        status_v[ST_TMA]      = st.tx_ack_flag;
        status_v[ST_TA]       = st.tx_available_flag;

        diag_v                = RST_ZERO;
        diag_v[DG_MYREC]      = st.self_caused_reconfig_flag;
        diag_v[DG_DUP]        = st.duplicate_node_flag;
        diag_v[DG_RACT]       = st.rx_activity_flag;
        diag_v[DG_TOKEN]      = st.token_seen_flag;
        diag_v[DG_XNAK]       = st.excess_nak_flag;
        diag_v[DG_TENT]       = st.probe_id_match_flag;
        diag_v[DG_NXTID]      = st.successor_changed_flag;
    end

    // command decode on the completing write
    assign cmd_etx = wr & (paddr == OFS_CMD)
                   & ((wbyte & CMD_ETX_MASK) == CMD_ETX_CODE);
    assign cmd_dis = wr & (paddr == OFS_CMD) & (wbyte == CMD_DIS_TX);
    assign cmd_clr = wr & (paddr == OFS_CMD)
                   & ((wbyte & CMD_CLR_MASK) == CMD_CLR_CODE);

    assign soft_rst = st.cfg[CF_SRESET];
    assign nak_lim  = st.cfg[CF_FOURNAK] ? NAK_FEW : NAK_MANY;
    // read-clear only hits bits the host saw
    assign clr_dg   = access_ph & ~pwrite & st.rd_diag;

    // interrupt from masked sticky flags
    assign irq = |(st.interrupt_mask_reg & {4'h0,
                  st.excess_nak_flag, st.line_idle_timeout_flag,
                  st.successor_changed_flag, st.tx_available_flag});

    assign eng.tx_start  = st.tx_start;
    assign eng.tx_page   = st.page;
    assign eng.tx_enable = st.cfg[CF_TXEN];

    // next state of the whole block
    always_comb begin
        next_st          = st;
        next_st.tx_start = 1'b0;

        // apb read capture in setup, side effects at access
        if (setup_ph) begin
            next_st.err     = ~mapped;
            next_st.rd_diag = ~pwrite & (paddr == OFS_DIAG);
            next_st.rd_next = ~pwrite & (paddr == OFS_NEXTID);
            case (paddr)
                OFS_STATUS: next_st.rdata = status_v;
                OFS_DIAG:   next_st.rdata = diag_v;
                OFS_MASK:   next_st.rdata = st.interrupt_mask_reg;
                OFS_CONFIG: next_st.rdata = st.cfg;
                OFS_DUPLICATE_NODE_FLAG:  next_st.rdata = st.dup_id;
                OFS_PROBE_ID_MATCH_FLAG: next_st.rdata = st.tent_id;
                OFS_NEXTID: next_st.rdata = net.next_id;
                default:    next_st.rdata = RST_ZERO;
            endcase
        end

        // diag read clears; successor, excess nak survive
        if (clr_dg) begin
            if (st.rdata[DG_MYREC]) begin
                next_st.self_caused_reconfig_flag = 1'b0;
            end

            if (st.rdata[DG_DUP]) begin
                next_st.duplicate_node_flag = 1'b0;
            end

            if (st.rdata[DG_RACT]) begin
                next_st.rx_activity_flag = 1'b0;
            end

            if (st.rdata[DG_TOKEN]) begin
                next_st.token_seen_flag = 1'b0;
            end

            if (st.rdata[DG_TENT]) begin
                next_st.probe_id_match_flag = 1'b0;
            end
        end
        if (access_ph & ~pwrite & st.rd_next) begin
            next_st.successor_changed_flag = 1'b0;
        end

        // plain register writes
        if (wr) begin
            case (paddr)
                OFS_MASK:   next_st.interrupt_mask_reg = wbyte;
                OFS_CONFIG: next_st.cfg = wbyte;
                OFS_DUPLICATE_NODE_FLAG:  next_st.dup_id = wbyte;
                OFS_PROBE_ID_MATCH_FLAG: next_st.tent_id = wbyte;
                default: ;
            endcase
        end

        // clear flags command
        if (cmd_clr) begin
            if (wbyte[CL_LINE_IDLE_TIMEOUT_FLAG]) begin
                next_st.line_idle_timeout_flag = 1'b0;
            end

            if (wbyte[CL_POR]) begin
                next_st.por_flag        = 1'b0;
                next_st.excess_nak_flag = 1'b0;
            end
        end

        // transmit sequencer
        case (st.tx_state)
            NSDF_TX_IDLE: begin
                if (cmd_dis) begin
                    next_st.tx_state = NSDF_TX_STOP;
                end
            end

            NSDF_TX_PEND: begin
                if (cmd_dis) begin
                    next_st.tx_state = NSDF_TX_STOP;
                end else if (net.token_held) begin
                    next_st.tx_state          = NSDF_TX_SEND;
                    next_st.tx_available_flag = 1'b0;
                    next_st.tx_start          = 1'b1;
                end
            end

            NSDF_TX_SEND: begin
                if (net.tx_last) begin
                    next_st.tx_state          = NSDF_TX_IDLE;
                    next_st.tx_available_flag = 1'b1;
                end
            end

            NSDF_TX_STOP: begin
                if (net.token_held) begin
                    next_st.tx_state          = NSDF_TX_IDLE;
                    next_st.tx_available_flag = 1'b1;
                end
            end

            default: next_st.tx_state = NSDF_TX_IDLE;
        endcase
        // new transmit request overrides idle or stopping
        if (cmd_etx & (st.tx_state != NSDF_TX_SEND)) begin
            next_st.tx_state    = NSDF_TX_PEND;
            next_st.page        = wbyte[5:3];
            next_st.tx_ack_flag = 1'b0;
            next_st.nak_cnt     = RST_ZERO;
        end
        // ack of a directed packet; a broadcast is never acknowledged
        if (net.ack_rx & ~net.tx_bcast & (st.tx_state == NSDF_TX_SEND)) begin
            next_st.tx_ack_flag = 1'b1;
        end

        // line idle timer, restarted by activity, fires once
        if (line_receive_input) begin
            next_st.idle_cnt         = 12'h000;
            next_st.idle_done        = 1'b0;
            next_st.rx_activity_flag = 1'b1;
        end else if (!st.idle_done) begin
            if (st.idle_cnt == IDLE_LAST) begin
                next_st.idle_done              = 1'b1;
                next_st.line_idle_timeout_flag = 1'b1;
            end else begin
                next_st.idle_cnt = st.idle_cnt + 12'h001;
            end
        end

        // token seen; match kept for the later response
        if (net.token_obs) begin
            next_st.tok_dup  = (net.did1 == st.dup_id)
                             & (net.did2 == st.dup_id) & net.zeros_ok;
            next_st.tok_tent = (net.did1 == st.tent_id);
            if (net.token_other) begin
                next_st.token_seen_flag = 1'b1;
            end
        end
        if (net.response & st.tok_dup) begin
            next_st.duplicate_node_flag = 1'b1;
        end

        if (net.response & st.tok_tent) begin
            next_st.probe_id_match_flag = 1'b1;
        end

        if (net.token_held & st.cfg[CF_TXEN]) begin
            next_st.duplicate_node_flag = 1'b1;
        end

        if (net.lost_token) begin
            next_st.self_caused_reconfig_flag = 1'b1;
        end

        // excess nak: cleared while tx available; a nak in the same cycle sets it and wins
        if (next_st.tx_available_flag) begin
            next_st.excess_nak_flag = 1'b0;
        end

        if (net.nak_rx) begin
            if (st.nak_cnt < NAK_MANY) begin
                next_st.nak_cnt = st.nak_cnt + 8'h01;
            end
            if ((st.nak_cnt + 8'h01) >= nak_lim) begin
                next_st.excess_nak_flag = 1'b1;
            end
        end

        if (net.next_upd) begin
            next_st.successor_changed_flag = 1'b1;
        end

        // software reset restores flag reset patterns
        if (soft_rst) begin
            next_st.tx_state                  = NSDF_TX_IDLE;
            next_st.tx_available_flag         = RST_STATUS[ST_TA];
            next_st.tx_ack_flag               = RST_STATUS[ST_TMA];
            next_st.line_idle_timeout_flag    = RST_STATUS[ST_LINE_IDLE_TIMEOUT_FLAG];
            next_st.por_flag                  = RST_STATUS[ST_POR];
            next_st.rx_inhibit_flag           = RST_STATUS[ST_RI];

            next_st.self_caused_reconfig_flag = RST_DIAG[DG_MYREC];
            next_st.duplicate_node_flag       = RST_DIAG[DG_DUP];
            next_st.rx_activity_flag          = RST_DIAG[DG_RACT];
            next_st.token_seen_flag           = RST_DIAG[DG_TOKEN];
            next_st.excess_nak_flag           = RST_DIAG[DG_XNAK];
            next_st.probe_id_match_flag       = RST_DIAG[DG_TENT];
            next_st.successor_changed_flag    = RST_DIAG[DG_NXTID];

            next_st.nak_cnt                   = RST_ZERO;
            next_st.tx_start                  = 1'b0;
        end
    end

    // state register; hardware reset loads the reset patterns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                           <= '0;
            st.tx_state                  <= NSDF_TX_IDLE;
            st.tx_available_flag         <= RST_STATUS[ST_TA];
            st.por_flag                  <= RST_STATUS[ST_POR];
            st.rx_inhibit_flag           <= RST_STATUS[ST_RI];
            st.successor_changed_flag    <= RST_DIAG[DG_NXTID];
        end else if (clk_en) begin
            st <= next_st;
        end
    end

endmodule : nsdf_top

/* tb/nsdf_props.sv */
// nsdf_props: port-level checks of nsdf_top
// assumes clk_en held high
`timescale 1ns/1ns
module nsdf_props
    import nsdf_pkg::*;
(
    input wire logic        pclk,    // clock
    input wire logic        presetn, // reset, active low
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb access
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr, // apb error
    input nsdf_net_t        net,     // engine events
    input nsdf_eng_t        eng,     // engine requests
    input wire logic        irq      // interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero wait states; error only in access
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("stray pslverr");
    property p_unmap;
        psel && penable && (paddr > OFS_NEXTID || paddr[1:0] != 2'b00)
        |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped accepted");
    // status test bit reads zero, upper lanes empty
    property p_test0;
        psel && penable && !pwrite && paddr == OFS_STATUS
        |-> !prdata[ST_TEST] && prdata[31:8] == 24'h00_0000;
    endproperty
    a_test0: assert property (p_test0) else $error("test bit set");
    // tx start: one cycle, after token held
    property p_start; eng.tx_start |-> $past(net.token_held) ##1 !eng.tx_start;
    endproperty
    a_start: assert property (p_start) else $error("bad tx start");
    property p_txen;
        psel && penable && pwrite && paddr == OFS_CONFIG
        |=> eng.tx_enable == $past(pwdata[CF_TXEN]);
    endproperty
    a_txen: assert property (p_txen) else $error("tx enable wrong");
    // next id read shows the value captured at setup
    property p_next;
        psel && penable && !pwrite && paddr == OFS_NEXTID
        |-> prdata[7:0] == $past(net.next_id);
    endproperty
    a_next: assert property (p_next) else $error("next id wrong");
    // irq falls only after access, token or tx end
    property p_irq_fall;
        $fell(irq) |-> $past(psel && penable) || $past(net.token_held)
                       || $past(net.tx_last) || $past(net.tx_last, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
    c_start: cover property (eng.tx_start);
    c_err: cover property (psel && penable && pslverr);
    c_irq: cover property ($rose(irq));
endmodule : nsdf_props

bind nsdf_top nsdf_props u_nsdf_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .net(net), .eng(eng), .irq(irq)
);

/* tb/nsdf_node_model.sv */
// nsdf_node_model: line engine and far nodes, drives network events
// assumes callers enter its tasks after a pclk edge
`timescale 1ns/1ns
module nsdf_node_model
    import nsdf_pkg::*;
(
    input  wire logic pclk, // 50 MHz clock
    input  nsdf_eng_t eng,  // requests from the block
    output nsdf_net_t net   // events toward the block
);
    initial net = '0;
    // one-cycle event; next_id is kept
    task automatic ev(input nsdf_net_t v);
        if (!v.next_upd) v.next_id = net.next_id;
        @(posedge pclk);
        net <= v;
        @(posedge pclk);
        net <= '{next_id: v.next_id, default: '0};
    endtask : ev
    // token, start, naks, then ack
    task automatic send(input int naks, input logic ack, input logic bc,
                        input int gap);
        int n;
        ev('{token_held: 1'b1, default: '0});
        n = 0;
        while (eng.tx_start !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) network_status_diag_flags_tb.n_errors++;
        repeat (gap) @(posedge pclk);
        repeat (naks) ev('{nak_rx: 1'b1, default: '0});
        ev('{ack_rx: ack, tx_bcast: bc, default: '0});
    endtask : send
    task automatic finish;
        ev('{tx_last: 1'b1, default: '0});
    endtask : finish
endmodule : nsdf_node_model

/* tb/network_status_diag_flags_tb.sv */
// network_status_diag_flags_tb: self-checking bench of nsdf_top
// assumes nsdf_node_model as the line engine
`timescale 1ns/1ns
module network_status_diag_flags_tb
    import nsdf_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, irq, pready;
    logic        pslverr, line_rx, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    nsdf_net_t   net;
    nsdf_eng_t   eng;
    int          n_errors, comparisons;

    nsdf_top u_nsdf_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_receive_input(line_rx), .net(net),
        .eng(eng), .irq(irq));
    nsdf_node_model u_nsdf_node_model (.pclk(pclk), .eng(eng), .net(net));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_errors++;
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r & m, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    // irq checked mid-cycle
    task automatic qi(input logic e);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : qi
    task automatic t_reset;
        rd(OFS_STATUS, 32'h0000_009F, 32'h0000_0091);
        rd(OFS_DIAG, 32'h0000_00FE, 32'h0000_0000);
        qi(1'b0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_idle;
        repeat (2020) @(posedge pclk);
        rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
        repeat (30) @(posedge pclk);
        rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        wr(OFS_MASK, 32'h0000_0004);
        qi(1'b1);
        rd(OFS_DIAG, 32'h0000_0020, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        wr(OFS_CMD, 32'h0000_0016);
        rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
        line_rx <= 1'b1;
        qi(1'b0);
        rd(OFS_DIAG, 32'h0000_0020, 32'h0000_0020);
        $display("t_idle done");
    endtask : t_idle
    task automatic t_tx;
        wr(OFS_CONFIG, 32'h0000_0001);
        wr(OFS_CMD, 32'h0000_001B);
        rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
        u_nsdf_node_model.send(3, 1'b1, 1'b0, 0);
        chk({29'h0, eng.tx_page}, 32'h0000_0003);
        rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0000);
        u_nsdf_node_model.ev('{nak_rx: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0008);
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0008);
        wr(OFS_MASK, 32'h0000_0008);
        qi(1'b1);
        u_nsdf_node_model.finish();
        rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0000);
        wr(OFS_CONFIG, 32'h0000_0000);
        wr(OFS_CMD, 32'h0000_001B);
        rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
        u_nsdf_node_model.send(127, 1'b1, 1'b1, 5);
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0000);
        u_nsdf_node_model.ev('{nak_rx: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_0008, 32'h0000_0008);
        u_nsdf_node_model.finish();
        rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_diag;
        wr(OFS_DUPLICATE_NODE_FLAG, 32'h0000_005A);
        wr(OFS_PROBE_ID_MATCH_FLAG, 32'h0000_0033);
        u_nsdf_node_model.ev('{token_obs: 1'b1, token_other: 1'b1,
            did1: 8'h5A, did2: 8'h5A, zeros_ok: 1'b1, default: '0});
        u_nsdf_node_model.ev('{response: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_00D4, 32'h0000_0050);
        rd(OFS_DIAG, 32'h0000_00D4, 32'h0000_0000);
        u_nsdf_node_model.ev('{token_obs: 1'b1, did1: 8'h33, default: '0});
        u_nsdf_node_model.ev('{response: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_00D4, 32'h0000_0004);
        u_nsdf_node_model.ev('{lost_token: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_00D4, 32'h0000_0080);
        wr(OFS_CONFIG, 32'h0000_0002);
        u_nsdf_node_model.ev('{token_held: 1'b1, default: '0});
        rd(OFS_DIAG, 32'h0000_00D4, 32'h0000_0040);
        wr(OFS_CONFIG, 32'h0000_0000);
        $display("t_diag done");
    endtask : t_diag
    task automatic t_next;
        u_nsdf_node_model.ev('{next_upd: 1'b1, next_id: 8'h42,
            default: '0});
        rd(OFS_DIAG, 32'h0000_0002, 32'h0000_0002);
        rd(OFS_DIAG, 32'h0000_0002, 32'h0000_0002);
        wr(OFS_MASK, 32'h0000_0002);
        qi(1'b1);
        rd(OFS_NEXTID, 32'h0000_00FF, 32'h0000_0042);
        rd(OFS_DIAG, 32'h0000_0002, 32'h0000_0000);
        qi(1'b0);
        $display("t_next done");
    endtask : t_next
    // unmapped: error, zero data
    task automatic t_bad;
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        chk({31'h0, last_err}, 32'h0000_0001);
        wr(8'h24, 32'h0000_00FF);
        chk({31'h0, last_err}, 32'h0000_0001);
        $display("t_bad done");
    endtask : t_bad
    task automatic end_sim;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // watchdog: the tests take under 5000 cycles
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
    // idle line runs the idle timer
    initial begin
        n_errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        line_rx = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_idle();
        t_tx();
        t_diag();
        t_next();
        t_bad();
        end_sim();
    end
endmodule : network_status_diag_flags_tb
